/* File: design/rcos_cfg.svh */
// Constants for the reset and clock output sequencer
`ifndef RCOS_CFG_SVH
`define RCOS_CFG_SVH

// Cycles the reset pin passes through before logic reads it
`define RCOS_SYNC_STAGES 2
// Strap sampling window before the reset pin rises, in clock cycles
`define RCOS_STRAP_WINDOW 10
// Least running-clock time before the reset pin rises, in clock cycles
`define RCOS_CLK_STABLE_CYCLES 10
// First fetch after the reset pin rises, in clock cycles
`define RCOS_FETCH_DELAY 80
// Post-release counter target, sync latency and state hop removed
`define RCOS_FETCH_WAIT (`RCOS_FETCH_DELAY - `RCOS_SYNC_STAGES - 1)
// Length of an internal reset raised by the lockup guard timer
`define RCOS_WD_HOLD_CYCLES 16
// Counter width
`define RCOS_CNT_W 8
// Strap latch values before any external reset has been seen
`define RCOS_BOOT_8BIT_RST 1'b0
`define RCOS_TRISTATE_RST 1'b0
// Fetch address forced by any reset
`define RCOS_RESET_VECTOR 32'h0000_0000

`endif

/* File: design/rcos_pkg.sv */
// Types for the reset and clock output sequencer
package rcos_pkg;

   typedef enum logic [2:0] {
      RCOS_ST_RESET = 3'h1,
      RCOS_ST_WAIT = 3'h2,
      RCOS_ST_RUN = 3'h4
   } rcos_state_e;

   typedef logic [7:0] rcos_cnt_t;

endpackage

/* File: design/rcos_strap_window.sv */
// Sliding history of one strap level over the last few cycles
`timescale 1ns/1ps

module rcos_strap_window #(
   parameter int DEPTH = 10
) (
   input wire logic clk_in,
   input wire logic ce_in,
   input wire logic capture_in,
   input wire logic level_in,
   output logic latest_out,
   output logic all_low_out
);

   logic [DEPTH-1:0] hist;
   logic [DEPTH-1:0] next_hist;

   // No reset: history only matters while capture runs
   assign next_hist = {hist[DEPTH-2:0], level_in};

   always_ff @(posedge clk_in) begin
      if (ce_in && capture_in) begin
         hist <= next_hist;
      end
   end

   assign latest_out = hist[0];
   assign all_low_out = ~|hist;

endmodule // rcos_strap_window

/* File: design/rcos_sequencer.sv */
// Reset sequencing, strap capture and clock-out pin control
// Functional notes
// - Reset is entered asynchronously when the reset pin falls and left in step with the clock.
// - The first processor fetch is held off until 80 cycles after the reset pin rises.
// - Any reset returns peripheral registers to defaults and forces the next fetch to address zero.
// - Only the program counter gets a defined value; general processor registers stay untouched.
// - While the reset pin is low the clock-out pin value is held constantly low; in tri-state mode its driver stays off.
// - After reset the clock-out pin carries a copy of the master clock.
// - The clock-out pin acts as plain I/O only once the I/O controller selects that use.
// - After reset every peripheral I/O pin is configured as an input.
// - A timer-raised internal reset has the core, peripheral, I/O and fetch effects of a reset pin assertion, but the clock copy keeps running.
// - A timer-raised reset samples no straps and keeps the latched boot and tri-state modes.
// - A reset pin assertion during a timer reset request wins, straps included.
// - Boot width is sampled in the last 10 cycles before the pin rises, high meaning 8-bit.
// - A float strap low over the last 10 cycles before the pin rises enables tri-state mode.
// - The memory remap is cleared only by an internal reset or a reset pin assertion.
`timescale 1ns/1ps
`include "rcos_cfg.svh"

module rcos_sequencer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic ext_reset_n_pin_in,
   input wire logic lockup_guard_timer_rst_en_in,
   input wire logic lockup_guard_timer_fire_in,
   input wire logic boot_width_strap_in,
   input wire logic output_float_strap_in,
   input wire logic remap_cmd_in,
   input wire logic parallel_io_controller_sel_io_in,
   input wire logic parallel_io_controller_data_in,
   input wire logic parallel_io_controller_oe_in,
   output logic core_reset_out,
   output logic periph_reset_out,
   output logic [31:0] fetch_addr_out,
   output logic fetch_enable_out,
   output logic io_force_input_out,
   output logic boot_width_8bit_out,
   output logic tristate_mode_out,
   output logic remap_out,
   output logic reset_cause_ext_out,
   output logic master_clk_out_pin_out,
   output logic master_clk_out_pin_oe_out,
   output rcos_pkg::rcos_state_e state_out
);
   import rcos_pkg::*;

   // Reset pin synchronizer, cleared straight from the pin
   logic ext_sync1;
   logic ext_sync2;
   logic ext_prev;
   // Strap synchronizers
   logic boot_sync1;
   logic boot_sync2;
   logic float_sync1;
   logic float_sync2;
   // Sequencer
   rcos_state_e state;
   rcos_state_e next_state;
   rcos_cnt_t cnt;
   rcos_cnt_t next_cnt;
   logic cause_ext;
   logic next_cause_ext;
   logic clk_run;
   // Decodes
   logic ext_active;
   logic ext_rise;
   logic wd_fire;
   logic any_reset_req;
   logic hold_done;
   logic wait_done;
   logic boot_latest;
   logic float_all_low;
   logic in_reset;
   logic next_clk_oe;

   // Reset pin: async entry, release only through two clocked stages
   always_ff @(posedge clk_in or negedge ext_reset_n_pin_in) begin
      if (!ext_reset_n_pin_in) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
      end else if (ce_in) begin
         ext_sync1 <= 1'b1;
         ext_sync2 <= ext_sync1;
      end
   end

   // Edge detector idles high, so a quiet pin after power-on is no rise
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ext_prev <= 1'b1;
      end else if (ce_in) begin
         ext_prev <= ext_sync2;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         boot_sync1 <= 1'b0;
         boot_sync2 <= 1'b0;
      end else if (ce_in) begin
         boot_sync1 <= boot_width_strap_in;
         boot_sync2 <= boot_sync1;
      end
   end

   // Float strap idles high, the level of a normally driven board
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         float_sync1 <= 1'b1;
         float_sync2 <= 1'b1;
      end else if (ce_in) begin
         float_sync1 <= output_float_strap_in;
         float_sync2 <= float_sync1;
      end
   end

   assign ext_active = ~ext_sync2;
   // Rise seen for one cycle, in the cycle the second stage goes high
   assign ext_rise = ext_sync2 & ~ext_prev;
   // Pin reset masks the timer request entirely
   assign wd_fire = lockup_guard_timer_rst_en_in & lockup_guard_timer_fire_in & ~ext_active;
   assign any_reset_req = ext_active | wd_fire;
   // Compares end one short, the counter starts at zero
   assign hold_done = (cnt == 8'(`RCOS_WD_HOLD_CYCLES - 1));
   assign wait_done = (cnt == 8'(`RCOS_FETCH_WAIT - 1));

   // Strap history only runs while the pin holds reset
   rcos_strap_window #(
      .DEPTH(`RCOS_STRAP_WINDOW)
   ) u_boot_window (
      .clk_in(clk_in),
      .ce_in(ce_in),
      .capture_in(ext_active),
      .level_in(boot_sync2),
      .latest_out(boot_latest),
      .all_low_out()
   );

   rcos_strap_window #(
      .DEPTH(`RCOS_STRAP_WINDOW)
   ) u_float_window (
      .clk_in(clk_in),
      .ce_in(ce_in),
      .capture_in(ext_active),
      .level_in(float_sync2),
      .latest_out(),
      .all_low_out(float_all_low)
   );

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cause_ext = cause_ext;
      case (state)
         RCOS_ST_RESET: begin
            if (ext_active) begin
               next_cause_ext = 1'b1;
               next_cnt = '0;
            end else if (cause_ext || hold_done) begin
               next_state = RCOS_ST_WAIT;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         RCOS_ST_WAIT: begin
            if (any_reset_req) begin
               next_state = RCOS_ST_RESET;
               next_cause_ext = ext_active;
               next_cnt = '0;
            end else if (wait_done) begin
               next_state = RCOS_ST_RUN;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         RCOS_ST_RUN: begin
            if (any_reset_req) begin
               next_state = RCOS_ST_RESET;
               next_cause_ext = ext_active;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = RCOS_ST_RESET;
            next_cnt = '0;
         end
      endcase
   end

   assign in_reset = (next_state == RCOS_ST_RESET);

   // Sequencer registers; the pin forces reset without waiting for a clock
   always_ff @(posedge clk_in or negedge ext_reset_n_pin_in) begin
      if (!ext_reset_n_pin_in) begin
         state <= RCOS_ST_RESET;
         cnt <= '0;
         cause_ext <= 1'b1;
      end else if (rst_in) begin
         state <= RCOS_ST_RESET;
         cnt <= '0;
         cause_ext <= 1'b1;
      end else if (ce_in) begin
         state <= next_state;
         cnt <= next_cnt;
         cause_ext <= next_cause_ext;
      end
   end

   // Reset outputs: set by the pin at once, cleared in step with the sequencer
   always_ff @(posedge clk_in or negedge ext_reset_n_pin_in) begin
      if (!ext_reset_n_pin_in) begin
         core_reset_out <= 1'b1;
         periph_reset_out <= 1'b1;
         io_force_input_out <= 1'b1;
      end else if (rst_in) begin
         core_reset_out <= 1'b1;
         periph_reset_out <= 1'b1;
         io_force_input_out <= 1'b1;
      end else if (ce_in) begin
         core_reset_out <= in_reset;
         periph_reset_out <= in_reset;
         io_force_input_out <= in_reset;
      end
   end

   // Fetch gate and clock-copy run flag
   always_ff @(posedge clk_in or negedge ext_reset_n_pin_in) begin
      if (!ext_reset_n_pin_in) begin
         fetch_enable_out <= 1'b0;
         clk_run <= 1'b0;
      end else if (rst_in) begin
         fetch_enable_out <= 1'b0;
         clk_run <= 1'b0;
      end else if (ce_in) begin
         fetch_enable_out <= (next_state == RCOS_ST_RUN);
         // Clock copy stops only for a pin reset
         clk_run <= ~ext_active;
      end
   end

   // Straps: latched on pin release only, so timer resets leave them alone
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         boot_width_8bit_out <= `RCOS_BOOT_8BIT_RST;
         tristate_mode_out <= `RCOS_TRISTATE_RST;
      end else if (ce_in && ext_rise) begin
         boot_width_8bit_out <= boot_latest;
         tristate_mode_out <= float_all_low;
      end
   end

   // Remap: set by command, cleared by either reset source
   always_ff @(posedge clk_in or negedge ext_reset_n_pin_in) begin
      if (!ext_reset_n_pin_in) begin
         remap_out <= 1'b0;
      end else if (rst_in) begin
         remap_out <= 1'b0;
      end else if (ce_in) begin
         if (any_reset_req) begin
            remap_out <= 1'b0;
         end else if (remap_cmd_in && state == RCOS_ST_RUN) begin
            remap_out <= 1'b1;
         end
      end
   end

   // Pin enable: tri-state wins, I/O use only once selected
   assign next_clk_oe = ~tristate_mode_out &
      (parallel_io_controller_sel_io_in & ~in_reset ? parallel_io_controller_oe_in : 1'b1);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         master_clk_out_pin_oe_out <= 1'b1;
         reset_cause_ext_out <= 1'b1;
         state_out <= RCOS_ST_RESET;
      end else if (ce_in) begin
         master_clk_out_pin_oe_out <= next_clk_oe;
         reset_cause_ext_out <= next_cause_ext;
         state_out <= next_state;
      end
   end

   // Fetch vector is fixed; general registers are left to the core
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fetch_addr_out <= `RCOS_RESET_VECTOR;
      end else if (ce_in && in_reset) begin
         fetch_addr_out <= `RCOS_RESET_VECTOR;
      end
   end

   // A clock copy cannot come from a flop; gated by a registered run flag
   assign master_clk_out_pin_out = (parallel_io_controller_sel_io_in & ~core_reset_out) ?
      parallel_io_controller_data_in : (clk_in & clk_run);

endmodule // rcos_sequencer

/* File: verif/rcos_board.sv */
// Board reset source model: reset pin and strap pins
`timescale 1ns/1ps

module rcos_board (
   input wire logic clk_in,
   output logic ext_reset_n_out,
   output logic boot_strap_out,
   output logic float_strap_out
);
   initial begin
      ext_reset_n_out = 1'b1;
      boot_strap_out = 1'b0;
      float_strap_out = 1'b1;
   end

   // Straps wrong early, so a too-wide sample window is caught
   task automatic pulse(input logic b, input logic f);
      @(negedge clk_in);
      ext_reset_n_out <= 1'b0;
      boot_strap_out <= ~b;
      float_strap_out <= ~f;
      repeat (18) @(negedge clk_in);
      boot_strap_out <= b;
      float_strap_out <= f;
      repeat (12) @(negedge clk_in);
      ext_reset_n_out <= 1'b1;
      // Released straps flip, never hold the last level
      boot_strap_out <= ~b;
      float_strap_out <= ~f;
   endtask
endmodule // rcos_board

/* File: verif/rcos_checker.sv */
// Port assertions for the reset sequencer
`timescale 1ns/1ps

module rcos_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic ext_reset_n_pin_in,
   input wire logic lockup_guard_timer_rst_en_in,
   input wire logic lockup_guard_timer_fire_in,
   input wire logic remap_cmd_in,
   input wire logic parallel_io_controller_sel_io_in,
   input wire logic core_reset_out,
   input wire logic periph_reset_out,
   input wire logic [31:0] fetch_addr_out,
   input wire logic fetch_enable_out,
   input wire logic io_force_input_out,
   input wire logic boot_width_8bit_out,
   input wire logic tristate_mode_out,
   input wire logic remap_out,
   input wire logic reset_cause_ext_out,
   input wire logic master_clk_out_pin_out,
   input wire logic master_clk_out_pin_oe_out,
   input wire rcos_pkg::rcos_state_e state_out
);
   import rcos_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   // A held clock enable freezes the sequence, so timed checks stand down
   default disable iff (rst_in || !ce_in);
   wire logic in_run = (state_out == RCOS_ST_RUN);
   wire logic sel = parallel_io_controller_sel_io_in;

   sequence s_wake;
      $fell(core_reset_out);
   endsequence
   sequence s_wd_req;
      lockup_guard_timer_rst_en_in && lockup_guard_timer_fire_in && in_run;
   endsequence

   // Negedge: clock high just before, so a leaked copy shows
   property p_pin_low;
      @(negedge clk_in) disable iff (rst_in)
      !ext_reset_n_pin_in |-> core_reset_out && !master_clk_out_pin_out;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin low not honoured");
   property p_reset_fx;
      core_reset_out |-> periph_reset_out && io_force_input_out && !fetch_enable_out
         && fetch_addr_out == 32'h0;
   endproperty
   a_reset_fx: assert property (p_reset_fx) else $error("reset effects missing");
   property p_wake;
      disable iff (rst_in || !ce_in || !ext_reset_n_pin_in)
      s_wake |-> ##76 !fetch_enable_out ##1 fetch_enable_out;
   endproperty
   a_wake: assert property (p_wake) else $error("fetch delay wrong");
   property p_wd;
      disable iff (rst_in || !ce_in || !ext_reset_n_pin_in)
      s_wd_req |-> ##[1:2] (core_reset_out && !reset_cause_ext_out) [*8];
   endproperty
   a_wd: assert property (p_wd) else $error("timer reset wrong");
   property p_strap_keep;
      disable iff (rst_in || !ext_reset_n_pin_in)
      !reset_cause_ext_out |-> $stable(boot_width_8bit_out) && $stable(tristate_mode_out);
   endproperty
   a_strap_keep: assert property (p_strap_keep) else $error("strap changed");
   property p_remap;
      remap_cmd_in && in_run |-> ##[1:2] remap_out;
   endproperty
   a_remap: assert property (p_remap) else $error("remap missing");
   property p_mck;
      @(negedge clk_in) disable iff (rst_in)
      in_run && !sel && !$past(sel) && !tristate_mode_out
         |-> master_clk_out_pin_out && master_clk_out_pin_oe_out;
   endproperty
   a_mck: assert property (p_mck) else $error("no clock copy");
   property p_tri;
      tristate_mode_out |=> !master_clk_out_pin_oe_out;
   endproperty
   a_tri: assert property (p_tri) else $error("driver on in tri-state");
endmodule // rcos_checker

bind rcos_sequencer rcos_checker u_chk (.clk_in, .rst_in, .ce_in, .ext_reset_n_pin_in,
   .lockup_guard_timer_rst_en_in, .lockup_guard_timer_fire_in, .remap_cmd_in,
   .parallel_io_controller_sel_io_in, .core_reset_out, .periph_reset_out, .fetch_addr_out,
   .fetch_enable_out, .io_force_input_out, .boot_width_8bit_out, .tristate_mode_out,
   .remap_out, .reset_cause_ext_out, .master_clk_out_pin_out, .master_clk_out_pin_oe_out,
   .state_out);

/* File: verif/test_rcos_sequencer.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps

module test_rcos_sequencer;
   import rcos_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, remap_cmd_in = 1'b0;
   logic lockup_guard_timer_rst_en_in = 1'b0, lockup_guard_timer_fire_in = 1'b0;
   logic parallel_io_controller_sel_io_in = 1'b0, parallel_io_controller_data_in = 1'b0;
   logic parallel_io_controller_oe_in = 1'b0;
   logic ext_reset_n_pin_in, boot_width_strap_in, output_float_strap_in;
   logic core_reset_out, periph_reset_out, fetch_enable_out, io_force_input_out;
   logic boot_width_8bit_out, tristate_mode_out, remap_out, reset_cause_ext_out;
   logic master_clk_out_pin_out, master_clk_out_pin_oe_out;
   logic [31:0] fetch_addr_out;
   rcos_state_e state_out;
   int mismatches = 0, compares = 0;

   always #4 clk_in = ~clk_in;

   rcos_board u_brd (.clk_in, .ext_reset_n_out(ext_reset_n_pin_in),
      .boot_strap_out(boot_width_strap_in), .float_strap_out(output_float_strap_in));
   rcos_sequencer u_dut (.clk_in, .rst_in, .ce_in, .ext_reset_n_pin_in,
      .lockup_guard_timer_rst_en_in, .lockup_guard_timer_fire_in, .boot_width_strap_in,
      .output_float_strap_in, .remap_cmd_in, .parallel_io_controller_sel_io_in,
      .parallel_io_controller_data_in, .parallel_io_controller_oe_in, .core_reset_out,
      .periph_reset_out, .fetch_addr_out, .fetch_enable_out, .io_force_input_out,
      .boot_width_8bit_out, .tristate_mode_out, .remap_out, .reset_cause_ext_out,
      .master_clk_out_pin_out, .master_clk_out_pin_oe_out, .state_out);

   task automatic chk(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic t_pin(input logic b, input logic f);
      u_brd.pulse(b, f);
      chk(core_reset_out, 1'b1, "held");
      repeat (79) @(negedge clk_in);
      chk(fetch_enable_out, 1'b0, "early");
      @(negedge clk_in);
      chk(fetch_enable_out, 1'b1, "late");
      chk(fetch_addr_out === 32'h0, 1'b1, "addr");
      chk(boot_width_8bit_out, b, "boot");
      chk(tristate_mode_out, ~f, "tri");
      chk(reset_cause_ext_out, 1'b1, "cause");
      $display("pin reset done");
   endtask

   task automatic t_io();
      parallel_io_controller_sel_io_in = 1'b1;
      parallel_io_controller_data_in = 1'b1;
      #1 chk(master_clk_out_pin_out, 1'b1, "io hi");
      @(negedge clk_in);
      parallel_io_controller_data_in = 1'b0;
      #1 chk(master_clk_out_pin_out, 1'b0, "io lo");
      chk(master_clk_out_pin_oe_out, 1'b0, "io oe");
      @(negedge clk_in);
      parallel_io_controller_sel_io_in = 1'b0;
      @(posedge clk_in);
      #1 chk(master_clk_out_pin_out, 1'b1, "copy");
      @(negedge clk_in);
      chk(master_clk_out_pin_oe_out, 1'b1, "copy oe");
      $display("shared pin done");
   endtask

   task automatic t_timer();
      int n;
      n = 0;
      remap_cmd_in = 1'b1;
      @(negedge clk_in);
      remap_cmd_in = 1'b0;
      lockup_guard_timer_fire_in = 1'b1;
      @(negedge clk_in);
      chk(remap_out, 1'b1, "remap");
      repeat (2) @(negedge clk_in);
      // Disabled timer: the request must be ignored
      chk(core_reset_out, 1'b0, "wd off");
      lockup_guard_timer_rst_en_in = 1'b1;
      @(negedge clk_in);
      lockup_guard_timer_fire_in = 1'b0;
      repeat (2) @(negedge clk_in);
      chk(core_reset_out, 1'b1, "wd rst");
      chk(periph_reset_out & io_force_input_out, 1'b1, "periph");
      chk(remap_out, 1'b0, "unmap");
      chk(reset_cause_ext_out, 1'b0, "wd cause");
      while (state_out !== RCOS_ST_RUN && n < 120) begin
         @(negedge clk_in);
         n++;
      end
      chk(state_out === RCOS_ST_RUN, 1'b1, "rerun");
      chk(boot_width_8bit_out, 1'b1, "keep");
      $display("timer reset done");
   endtask

   // Held clock enable: a timer request must leave the running state alone
   task automatic t_freeze();
      ce_in = 1'b0;
      lockup_guard_timer_fire_in = 1'b1;
      repeat (3) @(negedge clk_in);
      chk(core_reset_out, 1'b0, "frozen");
      chk(state_out === RCOS_ST_RUN, 1'b1, "frozen state");
      lockup_guard_timer_fire_in = 1'b0;
      ce_in = 1'b1;
      @(negedge clk_in);
      chk(core_reset_out, 1'b0, "thawed");
      $display("freeze done");
   endtask

   // Timer request raised with the pin fall and held into the low phase
   task automatic t_prio();
      fork
         begin
            @(negedge clk_in);
            lockup_guard_timer_fire_in = 1'b1;
            repeat (4) @(negedge clk_in);
            lockup_guard_timer_fire_in = 1'b0;
         end
      join_none
      t_pin(1'b0, 1'b1);
   endtask

   task automatic t_tri();
      t_pin(1'b0, 1'b0);
      chk(master_clk_out_pin_oe_out, 1'b0, "float");
   endtask

   initial begin
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      t_pin(1'b1, 1'b1);
      t_io();
      t_timer();
      t_freeze();
      t_prio();
      t_tri();
      end_sim();
   end

   // About 450 cycles expected; far longer means a hang
   initial begin
      #20000;
      mismatches++;
      $display("BAD %0t timeout", $time);
      end_sim();
   end
endmodule // test_rcos_sequencer
